// ---- hdl/svl_pkg.sv ----
// Purpose: Constants and types for the minimum system rail and input
//          current limit register bank.
// Assumes: Word-level writes arrive from the port byte framing logic.
// Notes:   Codes are kept raw; scaling is done by the analog loops.
// Function
// - Min system rail code in bits 13..8, 256 mV to 8192 mV weights.
// - Min rail 1.024 V..16.128 V in 256 mV; out-of-range writes discarded.
// - Power-on min rail from cell count: 3.584/6.144/9.216/12.288 V.
// - Reserved upper bits set makes write invalid; low byte ignored.
// - Battery below min rail: switch in linear mode, rail held at minimum.
// - Battery above min rail: switch fully on when charging or supplementing.
// - Switch off: regulate system rail 160 mV above battery.
// - Input over limit or input voltage low: reduce charge current.
// - Input limit code: 50 mA offset, 50 mA steps, 50..6400 mA.
// - Host input code in bits 14..8; only bit 14 set at reset.
// - Adapter removal restores host input limit default.
// - Host input setting is a maximum, not a typical current.
// - Ext limit pin disabled by 0x31 bit 7 or pin above 4.0 V.
// - Read-only effective limit register shows limit used, same encoding.
// - After optimizer run, effective value may differ; register shows it.
package svl_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] SVL_OFS_EFF_LIMIT = 8'h22;
  localparam logic [7:0] SVL_OFS_MIN_SYS = 8'h3e;
  localparam logic [7:0] SVL_OFS_HOST_LIMIT = 8'h3f;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int SVL_MINSYS_LSB = 8;
  localparam int SVL_MINSYS_MSB = 13;
  localparam int SVL_LIMIT_LSB = 8;
  localparam int SVL_LIMIT_MSB = 14;
  localparam logic [15:0] SVL_MINSYS_RSVD_HI = 16'hc000;
  localparam logic [15:0] SVL_LIMIT_RSVD_HI = 16'h8000;

  // ---------------------------------------------------------------
  // Ranges and reset values
  // ---------------------------------------------------------------
  localparam logic [5:0] SVL_MINSYS_CODE_MIN = 6'h04;
  localparam logic [5:0] SVL_MINSYS_CODE_MAX = 6'h3f;
  localparam logic [5:0] SVL_MINSYS_1CELL = 6'h0e;
  localparam logic [5:0] SVL_MINSYS_2CELL = 6'h18;
  localparam logic [5:0] SVL_MINSYS_3CELL = 6'h24;
  localparam logic [5:0] SVL_MINSYS_4CELL = 6'h30;
  localparam logic [15:0] SVL_HOST_LIMIT_RST = 16'h4000;
  localparam logic [15:0] SVL_EFF_LIMIT_RST = 16'h0000;
  localparam int SVL_LIMIT_OFFSET_MA = 50;
  localparam int SVL_LIMIT_STEP_MA = 50;
  localparam int SVL_SYS_MARGIN_MV = 160;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    SVL_SW_OFF = 2'b00,
    SVL_SW_LINEAR = 2'b01,
    SVL_SW_FULL = 2'b10
  } svl_sw_mode_t;

  typedef enum logic [1:0] {
    SVL_AS_CMD = 2'b00,
    SVL_AS_LO = 2'b01,
    SVL_AS_HI = 2'b10
  } svl_asm_state_t;

  typedef struct packed {
    logic [7:0] cmd;
    logic [15:0] data;
  } svl_word_t;

endpackage : svl_pkg

// ---- hdl/svl_word_asm.sv ----
// Purpose: Collects command, low and high data bytes into one word.
// Assumes: Bytes arrive in port order: command, low byte, high byte.
// Notes:   A new frame start drops any half-received word.
`timescale 1ns/1ns
module svl_word_asm
  import svl_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  // Byte stream
  input wire logic frame_start_in,
  input wire logic byte_valid_in,
  input wire logic [7:0] byte_in,
  // Assembled word
  output svl_word_t word_out,
  output logic word_valid_out
);

  svl_asm_state_t state;
  logic [7:0] cmd_q;
  logic [7:0] lo_q;

  // ---------------------------------------------------------------
  // Byte sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      state <= SVL_AS_CMD;
      cmd_q <= 8'h00;
      lo_q <= 8'h00;
    end else if (clk_en_in) begin
      if (frame_start_in) begin
        state <= SVL_AS_CMD;
      end else if (byte_valid_in) begin
        case (state)
          SVL_AS_CMD: begin
            cmd_q <= byte_in;
            state <= SVL_AS_LO;
          end
          SVL_AS_LO: begin
            lo_q <= byte_in;
            state <= SVL_AS_HI;
          end
          SVL_AS_HI: begin
            state <= SVL_AS_CMD;
          end
          default: begin
            state <= SVL_AS_CMD;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      word_out <= '0;
      word_valid_out <= 1'b0;
    end else if (clk_en_in) begin
      word_valid_out <= byte_valid_in && !frame_start_in
                        && state == SVL_AS_HI;
      if (byte_valid_in && !frame_start_in && state == SVL_AS_HI) begin
        word_out <= '{cmd: cmd_q, data: {byte_in, lo_q}};
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking asm_cb @(posedge clock_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence s_three_bytes;
    (clk_en_in && frame_start_in) ##1
    (clk_en_in && !frame_start_in && byte_valid_in)[*3];
  endsequence

  AST_WORD_AFTER_THREE: assert property (
    s_three_bytes |=> word_valid_out)
    else $error("Word not emitted after three bytes");

  AST_NO_WORD_EARLY: assert property (
    (clk_en_in && frame_start_in) |=> !word_valid_out ##1 !word_valid_out)
    else $error("Word emitted before high byte");

endmodule : svl_word_asm

// ---- hdl/svl_limit_regs.sv ----
// Purpose: Minimum system rail, host input limit and effective limit
//          registers with switch mode and charge throttle decisions.
// Assumes: Comparator and pin levels are synchronous to clock_in.
// Notes:   Read data appears one cycle after the read request.
`timescale 1ns/1ns
module svl_limit_regs
  import svl_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  // Port byte stream
  input wire logic frame_start_in,
  input wire logic byte_valid_in,
  input wire logic [7:0] byte_in,
  // Port read request
  input wire logic rd_req_in,
  input wire logic [7:0] rd_cmd_in,
  // Straps and power path status
  input wire logic [1:0] cell_count_in,
  input wire logic adapter_present_in,
  input wire logic batt_below_minsys_in,
  input wire logic charging_in,
  input wire logic supplement_in,
  input wire logic input_over_limit_in,
  input wire logic input_under_vlimit_in,
  // External limit pin control
  input wire logic ext_pin_disable_bit_in,
  input wire logic ext_pin_above_4v_in,
  // Optimizer result
  input wire logic optimizer_active_in,
  input wire logic [6:0] optimizer_code_in,
  // Read answer
  output logic [15:0] rd_data_out,
  output logic rd_valid_out,
  output logic wr_reject_out,
  // Settings to the regulation loops
  output logic [5:0] minsys_code_out,
  output logic [6:0] host_limit_code_out,
  output logic [6:0] eff_limit_code_out,
  output svl_sw_mode_t sw_mode_out,
  output logic sys_at_minsys_out,
  output logic charge_throttle_out,
  output logic ext_pin_enable_out
);

  svl_word_t wr_word;
  logic wr_valid;
  logic por_pending;
  logic adapter_q;
  logic [5:0] minsys;
  logic [6:0] host_limit;
  logic [6:0] eff_limit;
  logic minsys_ok;
  logic limit_ok;
  logic adapter_removed;

  // Default min rail for the strapped cell count
  function automatic logic [5:0] cell_default(input logic [1:0] cells);
    case (cells)
      2'b00: cell_default = SVL_MINSYS_1CELL;
      2'b01: cell_default = SVL_MINSYS_2CELL;
      2'b10: cell_default = SVL_MINSYS_3CELL;
      default: cell_default = SVL_MINSYS_4CELL;
    endcase
  endfunction : cell_default

  svl_word_asm u_asm (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .frame_start_in(frame_start_in),
    .byte_valid_in(byte_valid_in),
    .byte_in(byte_in),
    .word_out(wr_word),
    .word_valid_out(wr_valid)
  );

  // ---------------------------------------------------------------
  // Write qualification
  // ---------------------------------------------------------------
  // Range check
  assign minsys_ok = (wr_word.data & SVL_MINSYS_RSVD_HI) == 16'h0000
    && wr_word.data[SVL_MINSYS_MSB:SVL_MINSYS_LSB] >= SVL_MINSYS_CODE_MIN
    && wr_word.data[SVL_MINSYS_MSB:SVL_MINSYS_LSB] <= SVL_MINSYS_CODE_MAX;
  assign limit_ok = (wr_word.data & SVL_LIMIT_RSVD_HI) == 16'h0000;
  assign adapter_removed = adapter_q && !adapter_present_in;

  // ---------------------------------------------------------------
  // Min system rail register
  // ---------------------------------------------------------------
  // Strap caught after reset release, never under reset
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      por_pending <= 1'b1;
      minsys <= SVL_MINSYS_4CELL;
    end else if (clk_en_in) begin
      por_pending <= 1'b0;
      if (por_pending) begin
        minsys <= cell_default(cell_count_in);
      end else if (wr_valid && wr_word.cmd == SVL_OFS_MIN_SYS
                   && minsys_ok) begin
        minsys <= wr_word.data[SVL_MINSYS_MSB:SVL_MINSYS_LSB];
      end
    end
  end

  // ---------------------------------------------------------------
  // Host input limit register
  // ---------------------------------------------------------------
  // Removal wins over a host write in the same cycle
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      adapter_q <= 1'b0;
      host_limit <= SVL_HOST_LIMIT_RST[SVL_LIMIT_MSB:SVL_LIMIT_LSB];
    end else if (clk_en_in) begin
      adapter_q <= adapter_present_in;
      if (adapter_removed) begin
        host_limit <= SVL_HOST_LIMIT_RST[SVL_LIMIT_MSB:SVL_LIMIT_LSB];
      end else if (wr_valid && wr_word.cmd == SVL_OFS_HOST_LIMIT
                   && limit_ok) begin
        host_limit <= wr_word.data[SVL_LIMIT_MSB:SVL_LIMIT_LSB];
      end
    end
  end

  // ---------------------------------------------------------------
  // Effective limit
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      eff_limit <= SVL_EFF_LIMIT_RST[SVL_LIMIT_MSB:SVL_LIMIT_LSB];
    end else if (clk_en_in) begin
      eff_limit <= optimizer_active_in ? optimizer_code_in : host_limit;
    end
  end

  // ---------------------------------------------------------------
  // Register reads and write rejects
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      rd_data_out <= 16'h0000;
      rd_valid_out <= 1'b0;
      wr_reject_out <= 1'b0;
    end else if (clk_en_in) begin
      rd_valid_out <= rd_req_in;
      wr_reject_out <= wr_valid
        && ((wr_word.cmd == SVL_OFS_MIN_SYS && !minsys_ok)
            || (wr_word.cmd == SVL_OFS_HOST_LIMIT && !limit_ok));
      if (rd_req_in) begin
        case (rd_cmd_in)
          SVL_OFS_MIN_SYS: rd_data_out <= {2'b00, minsys, 8'h00};
          SVL_OFS_HOST_LIMIT: rd_data_out <= {1'b0, host_limit, 8'h00};
          SVL_OFS_EFF_LIMIT: rd_data_out <= {1'b0, eff_limit, 8'h00};
          default: rd_data_out <= 16'h0000;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Power path decisions
  // ---------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      sw_mode_out <= SVL_SW_OFF;
      sys_at_minsys_out <= 1'b0;
    end else if (clk_en_in) begin
      if (batt_below_minsys_in) begin
        sw_mode_out <= SVL_SW_LINEAR;
        sys_at_minsys_out <= 1'b1;
      end else if (charging_in || supplement_in) begin
        sw_mode_out <= SVL_SW_FULL;
        sys_at_minsys_out <= 1'b0;
      end else begin
        sw_mode_out <= SVL_SW_OFF;
        sys_at_minsys_out <= 1'b0;
      end
    end
  end

  // Loops use the codes as maximum limits, offset applied in analog
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      minsys_code_out <= SVL_MINSYS_4CELL;
      host_limit_code_out <= SVL_HOST_LIMIT_RST[SVL_LIMIT_MSB:SVL_LIMIT_LSB];
      eff_limit_code_out <= SVL_EFF_LIMIT_RST[SVL_LIMIT_MSB:SVL_LIMIT_LSB];
      charge_throttle_out <= 1'b0;
      ext_pin_enable_out <= 1'b0;
    end else if (clk_en_in) begin
      minsys_code_out <= minsys;
      host_limit_code_out <= host_limit;
      eff_limit_code_out <= eff_limit;
      charge_throttle_out <= input_over_limit_in || input_under_vlimit_in;
      ext_pin_enable_out <= !ext_pin_disable_bit_in && !ext_pin_above_4v_in;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking reg_cb @(posedge clock_in);
  endclocking
  default disable iff (sys_rst_in);

  sequence s_bad_minsys_write;
    clk_en_in && wr_valid && wr_word.cmd == SVL_OFS_MIN_SYS && !minsys_ok
    && !por_pending;
  endsequence

  sequence s_removal;
    clk_en_in && adapter_q && !adapter_present_in;
  endsequence

  sequence s_good_limit_write;
    clk_en_in && wr_valid && wr_word.cmd == SVL_OFS_HOST_LIMIT && limit_ok
    && !adapter_removed;
  endsequence

  AST_LIMIT_STORE: assert property (
    s_good_limit_write |=>
    host_limit == $past(wr_word.data[SVL_LIMIT_MSB:SVL_LIMIT_LSB]))
    else $error("Valid host limit write not stored");

  AST_POR_DEFAULT: assert property (
    (clk_en_in && por_pending) |=>
    minsys == cell_default($past(cell_count_in)))
    else $error("Cell count default not loaded");

  AST_EXT_PIN_BIT: assert property (
    (clk_en_in && ext_pin_disable_bit_in) |=> !ext_pin_enable_out)
    else $error("Pin function enabled while host disabled it");

  AST_MINSYS_RANGE: assert property (
    s_bad_minsys_write |=> $stable(minsys) && wr_reject_out)
    else $error("Out of range min rail write took effect");

  AST_MINSYS_STORE: assert property (
    (clk_en_in && wr_valid && wr_word.cmd == SVL_OFS_MIN_SYS && minsys_ok
     && !por_pending) |=> minsys == $past(wr_word.data[13:8]))
    else $error("Valid min rail write not stored");

  AST_LIMIT_RSVD: assert property (
    (clk_en_in && wr_valid && wr_word.cmd == SVL_OFS_HOST_LIMIT
     && wr_word.data[15] && !adapter_removed) |=> $stable(host_limit))
    else $error("Host limit changed by invalid write");

  AST_REMOVAL_RESTORE: assert property (
    s_removal |=> host_limit == 7'h40 ##2 host_limit_code_out == 7'h40)
    else $error("Host limit not restored on adapter removal");

  AST_SW_LINEAR: assert property (
    (clk_en_in && batt_below_minsys_in) |=>
    sw_mode_out == SVL_SW_LINEAR && sys_at_minsys_out)
    else $error("Switch not linear with low battery");

  AST_SW_FULL: assert property (
    (clk_en_in && !batt_below_minsys_in && (charging_in || supplement_in))
    |=> sw_mode_out == SVL_SW_FULL)
    else $error("Switch not fully on while charging");

  AST_SW_OFF: assert property (
    (clk_en_in && !batt_below_minsys_in && !charging_in && !supplement_in)
    |=> sw_mode_out == SVL_SW_OFF && !sys_at_minsys_out)
    else $error("Switch not off when idle");

  AST_THROTTLE: assert property (
    (clk_en_in && (input_over_limit_in || input_under_vlimit_in))
    |=> charge_throttle_out)
    else $error("Charge not throttled on input overload");

  AST_EXT_PIN: assert property (
    (clk_en_in && ext_pin_above_4v_in) |=> !ext_pin_enable_out)
    else $error("Pin function enabled above 4 V");

  AST_EFF_READBACK: assert property (
    (clk_en_in && rd_req_in && rd_cmd_in == SVL_OFS_EFF_LIMIT) |=>
    rd_valid_out && rd_data_out == {1'b0, $past(eff_limit), 8'h00})
    else $error("Effective limit readback wrong");

  AST_OPT_FOLLOW: assert property (
    (clk_en_in && optimizer_active_in) |=>
    eff_limit == $past(optimizer_code_in))
    else $error("Effective limit ignores optimizer");

  AST_RSVD_ZERO: assert property (
    rd_valid_out |-> rd_data_out[7:0] == 8'h00 && !rd_data_out[15])
    else $error("Reserved read bits not zero");

endmodule : svl_limit_regs

// ---- verif/svl_host_model.sv ----
// Purpose: Host controller model on the block's byte and read port.
// Assumes: Requests launch on the falling edge of clock_in.
// Notes:   Released byte lines show the inverse of the last byte.
`timescale 1ns/1ns
module svl_host_model
  import svl_pkg::*;
(
  // Clock
  input wire logic clock_in,
  // Write byte stream
  output logic frame_start_out,
  output logic byte_valid_out,
  output logic [7:0] byte_out,
  // Read request and answer
  output logic rd_req_out,
  output logic [7:0] rd_cmd_out,
  input wire logic [15:0] rd_data_in,
  input wire logic rd_valid_in
);
  initial begin
    frame_start_out = 1'b0;
    byte_valid_out = 1'b0;
    byte_out = 8'h5a;
    rd_req_out = 1'b0;
    rd_cmd_out = 8'ha5;
  end

  // ------------------------------------------------------------
  // Word write: frame start, command, low byte, high byte
  // ------------------------------------------------------------
  task automatic write_word(input logic [7:0] cmd,
                            input logic [15:0] data);
    @(negedge clock_in);
    frame_start_out = 1'b1;
    @(negedge clock_in);
    frame_start_out = 1'b0;
    byte_valid_out = 1'b1;
    byte_out = cmd;
    @(negedge clock_in);
    byte_out = data[7:0];
    @(negedge clock_in);
    byte_out = data[15:8];
    @(negedge clock_in);
    byte_valid_out = 1'b0;
    byte_out = ~byte_out;
    // Settle time covers reject pulse and output update
    repeat (5) @(negedge clock_in);
  endtask : write_word

  // ------------------------------------------------------------
  // Register read, answer expected one edge after the request
  // ------------------------------------------------------------
  task automatic read_reg(input logic [7:0] cmd,
                          output logic [15:0] data, output bit got);
    got = 1'b0;
    data = 16'hxxxx;
    @(negedge clock_in);
    rd_req_out = 1'b1;
    rd_cmd_out = cmd;
    @(negedge clock_in);
    rd_req_out = 1'b0;
    rd_cmd_out = ~cmd;
    // Valid stands one cycle only; look at each falling edge
    for (int i = 0; i < 4 && !got; i++) begin
      if (rd_valid_in === 1'b1) begin
        got = 1'b1;
        data = rd_data_in;
      end else begin
        @(negedge clock_in);
      end
    end
  endtask : read_reg

  // low limit on release
  // 300 mA guards against a runaway setting after high-Z exit
  task automatic guard_low_limit();
    write_word(SVL_OFS_HOST_LIMIT, 16'h0500);
  endtask : guard_low_limit

  // bring-up without switch
  // Auto-wakeup off, then charge current; both live outside this bank
  task automatic no_switch_setup();
    write_word(8'h30, 16'h0000);
    write_word(8'h14, 16'h0100);
  endtask : no_switch_setup
endmodule : svl_host_model

// ---- verif/testbench.sv ----
// Purpose: Self-checking bench for the limit register bank.
// Assumes: Inputs change on the falling edge; one clock domain.
// Notes:   All port traffic goes through the host model.
`timescale 1ns/1ns
module testbench
  import svl_pkg::*;
;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic clk_en_in = 1'b1;
  logic [1:0] cell_count_in = 2'h0;
  logic adapter_present_in = 1'b1;
  logic batt_below_minsys_in = 1'b0;
  logic charging_in = 1'b0;
  logic supplement_in = 1'b0;
  logic input_over_limit_in = 1'b0;
  logic input_under_vlimit_in = 1'b0;
  logic ext_pin_disable_bit_in = 1'b0;
  logic ext_pin_above_4v_in = 1'b0;
  logic optimizer_active_in = 1'b0;
  logic [6:0] optimizer_code_in = 7'h00;
  logic frame_start;
  logic byte_valid;
  logic [7:0] byte_data;
  logic rd_req;
  logic [7:0] rd_cmd;
  logic [15:0] rd_data;
  logic rd_valid;
  logic wr_reject;
  logic [5:0] minsys_code;
  logic [6:0] host_code;
  logic [6:0] eff_code;
  svl_sw_mode_t sw_mode;
  logic sys_at_minsys;
  logic throttle;
  logic ext_en;
  int error_cnt = 0;
  int num_checks = 0;
  int rej_cnt = 0;
  int mv_cell[4] = '{3584, 6144, 9216, 12288};
  logic [15:0] ms_wr[6] = '{16'h0400, 16'h0300, 16'h3fff, 16'h4400,
                            16'h8400, 16'h0000};
  bit ms_ok[6] = '{1, 0, 1, 0, 0, 0};
  logic [15:0] hl_wr[4] = '{16'h0000, 16'h7fff, 16'h8100, 16'h1234};
  bit hl_ok[4] = '{1, 1, 0, 1};

  always #4 clock_in = ~clock_in;

  always @(posedge clock_in) begin
    if (wr_reject === 1'b1) begin
      rej_cnt++;
    end
  end

  svl_host_model host (
    .clock_in(clock_in), .frame_start_out(frame_start),
    .byte_valid_out(byte_valid), .byte_out(byte_data),
    .rd_req_out(rd_req), .rd_cmd_out(rd_cmd),
    .rd_data_in(rd_data), .rd_valid_in(rd_valid)
  );

  svl_limit_regs dut (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
    .frame_start_in(frame_start), .byte_valid_in(byte_valid),
    .byte_in(byte_data), .rd_req_in(rd_req), .rd_cmd_in(rd_cmd),
    .cell_count_in(cell_count_in), .adapter_present_in(adapter_present_in),
    .batt_below_minsys_in(batt_below_minsys_in),
    .charging_in(charging_in), .supplement_in(supplement_in),
    .input_over_limit_in(input_over_limit_in),
    .input_under_vlimit_in(input_under_vlimit_in),
    .ext_pin_disable_bit_in(ext_pin_disable_bit_in),
    .ext_pin_above_4v_in(ext_pin_above_4v_in),
    .optimizer_active_in(optimizer_active_in),
    .optimizer_code_in(optimizer_code_in),
    .rd_data_out(rd_data), .rd_valid_out(rd_valid),
    .wr_reject_out(wr_reject), .minsys_code_out(minsys_code),
    .host_limit_code_out(host_code), .eff_limit_code_out(eff_code),
    .sw_mode_out(sw_mode), .sys_at_minsys_out(sys_at_minsys),
    .charge_throttle_out(throttle), .ext_pin_enable_out(ext_en)
  );

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check_val(input string what, input logic [15:0] exp,
                           input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  task automatic rd_check(input logic [7:0] cmd, input logic [15:0] exp);
    logic [15:0] d;
    bit got;
    host.read_reg(cmd, d, got);
    check_val("read valid", 16'h0001, {15'h0, got});
    check_val("read data", exp, d);
  endtask : rd_check

  task automatic do_reset(input logic [1:0] cells);
    @(negedge clock_in);
    sys_rst_in = 1'b1;
    cell_count_in = cells;
    repeat (6) @(negedge clock_in);
    sys_rst_in = 1'b0;
    repeat (4) @(negedge clock_in);
  endtask : do_reset

  task automatic test_done();
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    logic [15:0] exp;
    int rej_exp;
    svl_sw_mode_t mode;
    for (int c = 0; c < 4; c++) begin
      do_reset(c[1:0]);
      rd_check(SVL_OFS_MIN_SYS, 16'((mv_cell[c] / 256) << 8));
      check_val("minsys out", 16'(mv_cell[c] / 256), 16'(minsys_code));
    end
    rd_check(SVL_OFS_HOST_LIMIT, 16'h4000);
    rd_check(SVL_OFS_EFF_LIMIT, 16'h4000);
    rd_check(8'h21, 16'h0000);
    // Range edges 1.024 V and 16.128 V, reserved bits, code 0
    exp = 16'((mv_cell[3] / 256) << 8);
    for (int i = 0; i < 6; i++) begin
      rej_exp = rej_cnt + (ms_ok[i] ? 0 : 1);
      if (ms_ok[i]) begin
        exp = ms_wr[i] & 16'h3f00;
      end
      host.write_word(SVL_OFS_MIN_SYS, ms_wr[i]);
      check_val("minsys reject", 16'(rej_exp), 16'(rej_cnt));
      rd_check(SVL_OFS_MIN_SYS, exp);
      check_val("minsys out", 16'(exp[13:8]), 16'(minsys_code));
    end
    exp = 16'h4000;
    for (int i = 0; i < 4; i++) begin
      rej_exp = rej_cnt + (hl_ok[i] ? 0 : 1);
      if (hl_ok[i]) begin
        exp = hl_wr[i] & 16'h7f00;
      end
      host.write_word(SVL_OFS_HOST_LIMIT, hl_wr[i]);
      check_val("limit reject", 16'(rej_exp), 16'(rej_cnt));
      rd_check(SVL_OFS_HOST_LIMIT, exp);
      check_val("host out", 16'(exp[14:8]), 16'(host_code));
      check_val("eff out", 16'(exp[14:8]), 16'(eff_code));
    end
    // Read-only place keeps its value and raises no reject
    rej_exp = rej_cnt;
    host.write_word(SVL_OFS_EFF_LIMIT, 16'h2200);
    rd_check(SVL_OFS_EFF_LIMIT, exp);
    check_val("ro reject", 16'(rej_exp), 16'(rej_cnt));
    optimizer_code_in = 7'h11;
    optimizer_active_in = 1'b1;
    repeat (3) @(negedge clock_in);
    rd_check(SVL_OFS_EFF_LIMIT, 16'h1100);
    rd_check(SVL_OFS_HOST_LIMIT, exp);
    optimizer_active_in = 1'b0;
    repeat (3) @(negedge clock_in);
    rd_check(SVL_OFS_EFF_LIMIT, exp);
    // Clock enable low freezes the effective limit
    clk_en_in = 1'b0;
    optimizer_active_in = 1'b1;
    repeat (3) @(negedge clock_in);
    check_val("eff frozen", 16'(exp[14:8]), 16'(eff_code));
    optimizer_active_in = 1'b0;
    clk_en_in = 1'b1;
    repeat (3) @(negedge clock_in);
    rej_exp = rej_cnt;
    host.no_switch_setup();
    check_val("setup reject", 16'(rej_exp), 16'(rej_cnt));
    rd_check(SVL_OFS_MIN_SYS, 16'h3f00);
    host.guard_low_limit();
    rd_check(SVL_OFS_HOST_LIMIT, 16'h0500);
    adapter_present_in = 1'b0;
    repeat (3) @(negedge clock_in);
    rd_check(SVL_OFS_HOST_LIMIT, 16'h4000);
    check_val("host out", 16'h0040, 16'(host_code));
    adapter_present_in = 1'b1;
    for (int i = 0; i < 32; i++) begin
      {batt_below_minsys_in, charging_in, supplement_in} = i[4:2];
      {input_over_limit_in, input_under_vlimit_in} = i[1:0];
      {ext_pin_disable_bit_in, ext_pin_above_4v_in} = i[1:0];
      repeat (2) @(negedge clock_in);
      mode = i[4] ? SVL_SW_LINEAR : (|i[3:2]) ? SVL_SW_FULL : SVL_SW_OFF;
      check_val("switch mode", 16'(mode), 16'(sw_mode));
      check_val("rail at min", 16'(i[4]), 16'(sys_at_minsys));
      check_val("throttle", 16'(|i[1:0]), 16'(throttle));
      check_val("ext pin", 16'(~|i[1:0]), 16'(ext_en));
    end
    test_done();
  end

  // Run needs about 310 cycles; limit allows about forty times that
  initial begin
    #100000;
    error_cnt++;
    test_done();
  end
endmodule : testbench
